/* design/dic_input_conditioning.sv */
`timescale 1ns/1ps
module dic_input_conditioning #(
  parameter int CHANNELS  = 2,
  parameter int IN_COUNT  = 6,
  parameter int OUT_COUNT = 5
) (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  dic_pkg::dic_req_t                  busReq,
  output dic_pkg::dic_rsp_t                  busRsp,
  input  dic_pkg::dic_sample_t [CHANNELS-1:0] rawSample,
  input  wire logic [IN_COUNT-1:0]           inputPins,
  input  wire logic [dic_pkg::STO_W-1:0]     torqueOffPins,
  input  wire logic [OUT_COUNT-1:0]          outputStates,
  input  wire logic [dic_pkg::SPEED_W-1:0]   motorSpeedMax,
  input  wire logic [dic_pkg::SPEED_W-1:0]   analogSpeedLimit,
  input  wire logic [dic_pkg::SPEED_W-1:0]   digitalSpeedLimit,
  input  wire logic [1:0]                    displaySelect,
  output logic [dic_pkg::STATUS_W-1:0]       displayData,
  output dic_pkg::dic_sample_t [CHANNELS-1:0] profileSample,
  output logic [dic_pkg::SPEED_W-1:0]        activeSpeedLimit
);
  import dic_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (CHANNELS != 2)
  begin : gBadChannels
    $error("dic_input_conditioning: parameter map holds two channels");
  end
  if (IN_COUNT < 1 || IN_COUNT > STATUS_W)
  begin : gBadInputs
    $error("dic_input_conditioning: IN_COUNT out of range");
  end
  if (OUT_COUNT < 1 || OUT_COUNT > STATUS_W)
  begin : gBadOutputs
    $error("dic_input_conditioning: OUT_COUNT out of range");
  end
  if (STO_W > STATUS_W)
  begin : gBadTorqueOff
    $error("dic_input_conditioning: torque off word too narrow");
  end
  if (MV_W > DATA_W)
  begin : gBadDataWidth
    $error("dic_input_conditioning: data word narrower than samples");
  end

  localparam int LIMIT_SOURCES = 4;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [IN_COUNT-1:0]             inMeta;
    logic [IN_COUNT-1:0]             inSync;
    logic [STO_W-1:0]                stoMeta;
    logic [STO_W-1:0]                stoSync;
    logic [OUT_COUNT-1:0]            outState;
    logic [CHANNELS-1:0][MV_W-1:0]   deadZone;
    logic [CHANNELS-1:0][MV_W-1:0]   correction;
    logic [SPEED_W-1:0]              speedCeiling;
    dic_rsp_t                        rsp;
    logic [STATUS_W-1:0]             display;
  } dic_main_state_t;

  dic_main_state_t                       state;
  dic_main_state_t                       next_state;
  dic_sample_t [CHANNELS-1:0]            corrected;
  logic [LIMIT_SOURCES-1:0][SPEED_W-1:0] limitSources;
  logic [STATUS_W-1:0]                   inputWord;
  logic [STATUS_W-1:0]                   outputWord;
  logic [STATUS_W-1:0]                   torqueWord;
  logic signed [MV_W-1:0]                wrSigned;
  logic [MV_W-1:0]                       wrUnsigned;
  logic [SPEED_W-1:0]                    wrSpeed;
  logic [STATUS_W-1:0]                   displayView;
  logic [DATA_W-1:0]                     readData;
  logic                                  readHit;
  logic [CHANNELS-1:0]                   wrDeadZoneHit;
  logic [CHANNELS-1:0]                   wrCorrectionHit;
  logic                                  wrCeilingHit;
  logic                                  writeHit;
  dic_rsp_t                              rspNext;

  // ****************************************************************
  // status words
  // ****************************************************************
  for (genvar b = 0; b < STATUS_W; b++)
  begin : gStatus
    if (b < IN_COUNT)
    begin : gIn
      assign inputWord[b] = state.inSync[b];
    end
    else
    begin : gInPad
      assign inputWord[b] = 1'b0;
    end
    if (b < OUT_COUNT)
    begin : gOut
      assign outputWord[b] = state.outState[b];
    end
    else
    begin : gOutPad
      assign outputWord[b] = 1'b0;
    end
    if (b < STO_W)
    begin : gOff
      assign torqueWord[b] = state.stoSync[b];
    end
    else
    begin : gOffPad
      assign torqueWord[b] = 1'b0;
    end
  end

  // ****************************************************************
  // write value shaping
  // ****************************************************************
  always_comb
  begin
    wrSigned = busReq.wdata[MV_W-1:0];
    if (wrSigned > CORR_LIMIT)
      wrSigned = CORR_LIMIT;
    else if (wrSigned < -CORR_LIMIT)
      wrSigned = -CORR_LIMIT;
  end

  always_comb
  begin
    wrUnsigned = busReq.wdata[MV_W-1:0];
    if (wrUnsigned > DZ_LIMIT)
      wrUnsigned = DZ_LIMIT;
  end

  always_comb
  begin
    wrSpeed = busReq.wdata;
    if (wrSpeed < SPEED_MIN)
      wrSpeed = SPEED_MIN;
    else if (wrSpeed > SPEED_MAX)
      wrSpeed = SPEED_MAX;
  end

  // ****************************************************************
  // view only display selection
  // ****************************************************************
  always_comb
  begin
    case (displaySelect)
      DISP_INPUTS:  displayView = inputWord;
      DISP_OUTPUTS: displayView = outputWord;
      DISP_TORQUE:  displayView = torqueWord;
      default:      displayView = '0;
    endcase
  end

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  always_comb
  begin
    readHit = 1'b1;
    readData = '0;
    case (busReq.addr)
      ADDR_AN1_VOLTAGE:
        readData = DATA_W'(corrected[0].mv);
      ADDR_AN2_VOLTAGE:
        readData = DATA_W'(corrected[1].mv);
      ADDR_AN1_DEADZONE:
        readData = DATA_W'(state.deadZone[0]);
      ADDR_AN2_DEADZONE:
        readData = DATA_W'(state.deadZone[1]);
      ADDR_AN1_CORRECT:
        readData = DATA_W'(signed'(state.correction[0]));
      ADDR_AN2_CORRECT:
        readData = DATA_W'(signed'(state.correction[1]));
      ADDR_SPEED_CEIL:
        readData = state.speedCeiling;
      ADDR_INPUT_PINS:
        readData = DATA_W'(inputWord);
      ADDR_OUTPUT_PINS:
        readData = DATA_W'(outputWord);
      ADDR_TORQUE_OFF:
        readData = DATA_W'(torqueWord);
      default:
        readHit = 1'b0;
    endcase
  end

  // ****************************************************************
  // write decoder, read-only and unmapped offsets refused
  // ****************************************************************
  always_comb
  begin
    wrDeadZoneHit = '0;
    wrCorrectionHit = '0;
    wrCeilingHit = 1'b0;
    case (busReq.addr)
      ADDR_AN1_DEADZONE:
        wrDeadZoneHit[0] = 1'b1;
      ADDR_AN2_DEADZONE:
        wrDeadZoneHit[1] = 1'b1;
      ADDR_AN1_CORRECT:
        wrCorrectionHit[0] = 1'b1;
      ADDR_AN2_CORRECT:
        wrCorrectionHit[1] = 1'b1;
      ADDR_SPEED_CEIL:
        wrCeilingHit = 1'b1;
      default:
        wrCeilingHit = 1'b0;
    endcase
    writeHit = |{wrDeadZoneHit, wrCorrectionHit, wrCeilingHit};
  end

  // ****************************************************************
  // response, one-cycle answer to each taken request
  // ****************************************************************
  always_comb
  begin
    rspNext = '0;
    if (busReq.req)
    begin
      rspNext.ack = 1'b1;
      if (busReq.write)
        rspNext.err = !writeHit;
      else
      begin
        rspNext.err = !readHit;
        rspNext.rdata = readData;
      end
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_state = state;

    // pin synchronisers for inputs and torque off, output states registered once
    next_state.inMeta = inputPins;
    next_state.inSync = state.inMeta;
    next_state.stoMeta = torqueOffPins;
    next_state.stoSync = state.stoMeta;
    next_state.outState = outputStates;

    // display readout, nothing on it writes state
    next_state.display = displayView;

    // accepted writes land in the parameter registers
    next_state.rsp = rspNext;
    if (busReq.req && busReq.write)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (wrDeadZoneHit[i])
          next_state.deadZone[i] = wrUnsigned;
        if (wrCorrectionHit[i])
          next_state.correction[i] = wrSigned;
      end
      if (wrCeilingHit)
        next_state.speedCeiling = wrSpeed;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // parameters return to their defaults
      state <= '0;
      for (int i = 0; i < CHANNELS; i++)
      begin
        state.deadZone[i] <= DZ_RESET;
        state.correction[i] <= CORR_RESET;
      end
      state.speedCeiling <= SPEED_RESET;
    end
    else
      state <= next_state;
  end

  // ****************************************************************
  // analog channels
  // ****************************************************************
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : gChan
    logic signed [MV_W-1:0] chCorrection;
    assign chCorrection = signed'(state.correction[ch]);
    dic_analog_conditioner uCond (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .rawSample  (rawSample[ch]),
      .correction (chCorrection),
      .deadZone   (state.deadZone[ch]),
      .corrected  (corrected[ch])
    );
  end

  assign profileSample = corrected;

  // ****************************************************************
  // speed limit
  // ****************************************************************
  // ceiling feeds the minimum directly, a write acts without restart
  assign limitSources[0] = state.speedCeiling;
  assign limitSources[1] = motorSpeedMax;
  assign limitSources[2] = analogSpeedLimit;
  assign limitSources[3] = digitalSpeedLimit;

  dic_limit_min #(
    .COUNT (LIMIT_SOURCES),
    .WIDTH (SPEED_W)
  ) uLimit (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .limits  (limitSources),
    .minimum (activeSpeedLimit)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign busRsp = state.rsp;
  assign displayData = state.display;
endmodule

/* design/dic_pkg.sv */
package dic_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int MV_W     = 16;
  localparam int SPEED_W  = 32;
  localparam int STATUS_W = 8;
  localparam int STO_W    = 2;

  // ****************************************************************
  // parameter offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_AN1_VOLTAGE  = 16'h0902;
  localparam logic [ADDR_W-1:0] ADDR_AN2_VOLTAGE  = 16'h090A;
  localparam logic [ADDR_W-1:0] ADDR_AN1_DEADZONE = 16'h0912;
  localparam logic [ADDR_W-1:0] ADDR_AN2_DEADZONE = 16'h0914;
  localparam logic [ADDR_W-1:0] ADDR_AN1_CORRECT  = 16'h0916;
  localparam logic [ADDR_W-1:0] ADDR_AN2_CORRECT  = 16'h0918;
  localparam logic [ADDR_W-1:0] ADDR_SPEED_CEIL   = 16'h1120;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_PINS   = 16'h0920;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_PINS  = 16'h0922;
  localparam logic [ADDR_W-1:0] ADDR_TORQUE_OFF   = 16'h0924;

  // ****************************************************************
  // ranges and reset values
  // ****************************************************************
  localparam logic signed [MV_W-1:0] MV_LIMIT   = 16'sh2710;
  localparam logic signed [MV_W-1:0] CORR_LIMIT = 16'sh1388;
  localparam logic [MV_W-1:0]        DZ_LIMIT   = 16'h03E8;
  localparam logic [MV_W-1:0]        DZ_RESET   = 16'h0000;
  localparam logic [MV_W-1:0]        CORR_RESET = 16'h0000;
  localparam logic [SPEED_W-1:0]     SPEED_RESET = 32'h0000_3390;
  localparam logic [SPEED_W-1:0]     SPEED_MIN   = 32'h0000_0001;
  localparam logic [SPEED_W-1:0]     SPEED_MAX   = 32'h7FFF_FFFF;

  // ****************************************************************
  // local display selection
  // ****************************************************************
  localparam logic [1:0] DISP_INPUTS  = 2'h0;
  localparam logic [1:0] DISP_OUTPUTS = 2'h1;
  localparam logic [1:0] DISP_TORQUE  = 2'h2;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dic_req_t;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } dic_rsp_t;

  typedef struct packed {
    logic                   valid;
    logic signed [MV_W-1:0] mv;
  } dic_sample_t;

endpackage

/* design/dic_analog_conditioner.sv */
`timescale 1ns/1ps
module dic_analog_conditioner (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  dic_pkg::dic_sample_t               rawSample,
  input  wire logic signed [dic_pkg::MV_W-1:0] correction,
  input  wire logic [dic_pkg::MV_W-1:0]      deadZone,
  output dic_pkg::dic_sample_t               corrected
);
  import dic_pkg::*;

  typedef struct packed {
    dic_sample_t out;
  } dic_cond_state_t;

  dic_cond_state_t        state;
  dic_cond_state_t        next_state;
  logic signed [MV_W+1:0] limit;
  logic signed [MV_W+1:0] rawWide;
  logic signed [MV_W+1:0] sum;
  logic signed [MV_W+1:0] mag;

  // ****************************************************************
  // offset, saturation, zero window
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_state.out.valid = 1'b0;
    limit = (MV_W+2)'(MV_LIMIT);
    rawWide = (MV_W+2)'(rawSample.mv);
    if (rawWide > limit)
      rawWide = limit;
    else if (rawWide < -limit)
      rawWide = -limit;
    sum = rawWide + (MV_W+2)'(correction);
    if (sum > limit)
      sum = limit;
    else if (sum < -limit)
      sum = -limit;
    mag = (sum < 0) ? -sum : sum;
    if (mag <= signed'({2'b00, deadZone}))
      sum = '0;
    if (rawSample.valid)
    begin
      next_state.out.valid = 1'b1;
      next_state.out.mv = sum[MV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state <= '0;
    else
      state <= next_state;
  end

  assign corrected = state.out;
endmodule

/* design/dic_limit_min.sv */
`timescale 1ns/1ps
module dic_limit_min #(
  parameter int COUNT = 4,
  parameter int WIDTH = 32
) (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic [COUNT-1:0][WIDTH-1:0] limits,
  output logic [WIDTH-1:0]                 minimum
);
  import dic_pkg::*;

  if (COUNT < 1 || WIDTH < 1)
  begin : gBadSize
    $error("dic_limit_min: COUNT and WIDTH must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] low;
  } dic_min_state_t;

  dic_min_state_t state;
  dic_min_state_t next_state;

  // ****************************************************************
  // lowest of all sources
  // ****************************************************************
  always_comb
  begin
    next_state.low = limits[0];
    for (int i = 1; i < COUNT; i++)
    begin
      if (limits[i] < next_state.low)
        next_state.low = limits[i];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state <= '0;
    else
      state <= next_state;
  end

  assign minimum = state.low;
endmodule

/* test/dic_io_source.sv */
`timescale 1ns/1ps
module dic_io_source (
  input  wire logic [1:0]        fire,
  input  wire logic [1:0][15:0]  mvIn,
  input  wire logic [5:0]        pinsIn,
  input  wire logic [1:0]        offIn,
  input  wire logic [4:0]        outIn,
  output dic_pkg::dic_sample_t [1:0] rawSample,
  output logic [5:0]             inputPins,
  output logic [1:0]             torqueOffPins,
  output logic [4:0]             outputStates
);
  import dic_pkg::*;

  function automatic logic [15:0] lim(logic signed [15:0] v);
    return (v > MV_LIMIT) ? MV_LIMIT : (v < -MV_LIMIT) ? -MV_LIMIT : v;
  endfunction

  // ****************************************************************
  // analog source, line shows inverse of last value between samples
  // ****************************************************************
  always @*
  begin
    for (int i = 0; i < 2; i++)
    begin
      rawSample[i].valid = fire[i];
      rawSample[i].mv = fire[i] ? lim(mvIn[i]) : ~mvIn[i];
    end
  end

  // ****************************************************************
  // pins change off the clock
  // ****************************************************************
  initial inputPins = '0;
  initial torqueOffPins = '0;
  always @(pinsIn) inputPins <= #7 pinsIn;
  always @(offIn) torqueOffPins <= #7 offIn;
  assign outputStates = outIn;
endmodule

/* test/dic_input_conditioning_asserts.sv */
`timescale 1ns/1ps
module dic_input_conditioning_asserts #(
  parameter int CHANNELS  = 2,
  parameter int IN_COUNT  = 6,
  parameter int OUT_COUNT = 5
) (
  input wire logic                           sys_clk,
  input wire logic                           nrst,
  input dic_pkg::dic_req_t                   busReq,
  input dic_pkg::dic_rsp_t                   busRsp,
  input dic_pkg::dic_sample_t [CHANNELS-1:0] rawSample,
  input wire logic [IN_COUNT-1:0]            inputPins,
  input wire logic [dic_pkg::STO_W-1:0]      torqueOffPins,
  input wire logic [OUT_COUNT-1:0]           outputStates,
  input wire logic [dic_pkg::SPEED_W-1:0]    motorSpeedMax,
  input wire logic [dic_pkg::SPEED_W-1:0]    analogSpeedLimit,
  input wire logic [dic_pkg::SPEED_W-1:0]    digitalSpeedLimit,
  input wire logic [1:0]                     displaySelect,
  input wire logic [dic_pkg::STATUS_W-1:0]   displayData,
  input dic_pkg::dic_sample_t [CHANNELS-1:0] profileSample,
  input wire logic [dic_pkg::SPEED_W-1:0]    activeSpeedLimit
);
  import dic_pkg::*;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_ack_follows_req: assert property (busReq.req |=> busRsp.ack)
    else $error("no ack after request");
  a_ack_needs_req: assert property (busRsp.ack |-> $past(busReq.req))
    else $error("ack without request");
  a_readonly_refused: assert property (busReq.req && busReq.write &&
    (busReq.addr == ADDR_AN1_VOLTAGE || busReq.addr == ADDR_INPUT_PINS)
    |=> busRsp.ack && busRsp.err) else $error("read-only write taken");
  a_rsp_idle_zero: assert property (!busRsp.ack |->
    busRsp.rdata == 0 && !busRsp.err) else $error("response not idle");
  a_sample_one_late: assert property ({profileSample[1].valid,
    profileSample[0].valid} == $past({rawSample[1].valid,
    rawSample[0].valid})) else $error("sample strobe latency");
  a_mv_in_range: assert property (profileSample[0].valid |->
    profileSample[0].mv <= MV_LIMIT && profileSample[0].mv >= -MV_LIMIT)
    else $error("corrected value out of range");
  a_mv_holds: assert property (!profileSample[0].valid |->
    $stable(profileSample[0].mv)) else $error("sample value moved");
  a_speed_lowest: assert property (activeSpeedLimit <=
    $past(motorSpeedMax) && activeSpeedLimit <= $past(analogSpeedLimit)
    && activeSpeedLimit <= $past(digitalSpeedLimit))
    else $error("speed limit above a source");
  a_in_unused_zero: assert property ($past(displaySelect) ==
    DISP_INPUTS |-> displayData[7:6] == 0) else $error("input bits");
  a_out_unused_zero: assert property ($past(displaySelect) ==
    DISP_OUTPUTS |-> displayData[7:5] == 0) else $error("output bits");
  a_off_own_view: assert property ($past(displaySelect) ==
    DISP_TORQUE |-> displayData[7:2] == 0) else $error("torque off bits");

  cover property (busReq.req && busReq.write);
  cover property (busRsp.err);
  cover property (profileSample[1].valid && profileSample[1].mv == 0);
endmodule

bind dic_input_conditioning dic_input_conditioning_asserts #(
  .CHANNELS(CHANNELS), .IN_COUNT(IN_COUNT), .OUT_COUNT(OUT_COUNT)
) u_dic_input_conditioning_asserts (.sys_clk, .nrst, .busReq, .busRsp,
  .rawSample, .inputPins, .torqueOffPins, .outputStates, .motorSpeedMax,
  .analogSpeedLimit, .digitalSpeedLimit, .displaySelect, .displayData,
  .profileSample, .activeSpeedLimit);

/* test/test_dic_input_conditioning.sv */
`timescale 1ns/1ps
module test_dic_input_conditioning;
  import dic_pkg::*;
  logic              sys_clk = 0;
  logic              nrst = 0;
  dic_req_t          busReq = '0;
  dic_rsp_t          busRsp;
  dic_sample_t [1:0] rawSample;
  dic_sample_t [1:0] profileSample;
  logic [1:0]        fire = 0;
  logic [1:0][15:0]  mvIn = '0;
  logic [5:0]        pinsIn = 0;
  logic [5:0]        inputPins;
  logic [1:0]        offIn = 0;
  logic [1:0]        torqueOffPins;
  logic [4:0]        outIn = 0;
  logic [4:0]        outputStates;
  logic [31:0]       motorSpeedMax = 32'h0000_FFFF;
  logic [31:0]       analogSpeedLimit = 32'h0000_FFFF;
  logic [31:0]       digitalSpeedLimit = 32'h0000_FFFF;
  logic [1:0]        displaySelect = 0;
  logic [7:0]        displayData;
  logic [31:0]       activeSpeedLimit;
  logic [31:0]       rd;
  logic [31:0]       ceil;
  logic              er;
  int                failures = 0;
  int                n_tests = 0;
  int                seed = 39432;
  int                ch, r, c, z;
  logic [15:0]       ra [5] = '{ADDR_AN1_DEADZONE, ADDR_AN2_DEADZONE,
                                ADDR_AN1_CORRECT, ADDR_AN2_CORRECT,
                                ADDR_SPEED_CEIL};

  always #25 sys_clk = ~sys_clk;

  dic_input_conditioning u_dic_input_conditioning (.sys_clk, .nrst,
    .busReq, .busRsp, .rawSample, .inputPins, .torqueOffPins,
    .outputStates, .motorSpeedMax, .analogSpeedLimit, .digitalSpeedLimit,
    .displaySelect, .displayData, .profileSample, .activeSpeedLimit);
  dic_io_source u_dic_io_source (.fire, .mvIn, .pinsIn, .offIn, .outIn,
    .rawSample, .inputPins, .torqueOffPins, .outputStates);

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick;
    @(posedge sys_clk);
    #2;
  endtask

  task automatic check(logic [31:0] got, logic [31:0] want);
    n_tests++;
    if (got !== want)
    begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic bus(logic w, logic [15:0] a, logic [31:0] d);
    busReq = '{1'b1, w, a, d};
    tick;
    busReq.req = 0;
    rd = busRsp.rdata;
    er = busRsp.err;
    check(busRsp.ack, 1);
    tick;
  endtask

  function automatic logic [31:0] sx(logic [15:0] m);
    return {{16{m[15]}}, m};
  endfunction

  function automatic int cond(int rv, int cv, int zv);
    int v;
    v = rv + cv;
    v = (v > 10000) ? 10000 : (v < -10000) ? -10000 : v;
    return (v <= zv && v >= -zv) ? 0 : v;
  endfunction

  function automatic logic [31:0] min4(logic [31:0] a, b, d, e);
    logic [31:0] m;
    m = (a < b) ? a : b;
    m = (d < m) ? d : m;
    return (e < m) ? e : m;
  endfunction

  task automatic sample(int k, int rv, int cv, int zv);
    logic [15:0] m;
    bus(1, k ? ADDR_AN2_CORRECT : ADDR_AN1_CORRECT, cv);
    bus(1, k ? ADDR_AN2_DEADZONE : ADDR_AN1_DEADZONE, zv);
    mvIn[k] = rv[15:0];
    fire[k] = 1;
    tick;
    fire[k] = 0;
    m = profileSample[k].mv;
    check(profileSample[k].valid, 1);
    check(sx(m), cond(rv, cv, zv));
    bus(0, k ? ADDR_AN2_VOLTAGE : ADDR_AN1_VOLTAGE, 0);
    check(rd, sx(m));
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    #250000;
    failures++;
    stop_test;
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    #2 nrst = 1;
    tick;
    check(activeSpeedLimit, SPEED_RESET);
    foreach (ra[i])
    begin
      bus(0, ra[i], 0);
      check(rd, (i == 4) ? SPEED_RESET : 32'h0);
    end
    bus(1, ADDR_AN1_CORRECT, -6000);
    bus(0, ADDR_AN1_CORRECT, 0);
    check(rd, -5000);
    bus(1, ADDR_AN2_DEADZONE, 2000);
    bus(0, ADDR_AN2_DEADZONE, 0);
    check(rd, 1000);
    bus(1, ADDR_AN1_VOLTAGE, 5);
    check(er, 1);
    bus(1, ADDR_INPUT_PINS, 5);
    check(er, 1);
    bus(0, 16'h0000, 0);
    check(er, 1);
    check(rd, 0);
    sample(0, 100, 20, 120);
    sample(1, 100, 20, 119);
    sample(0, 9000, 5000, 0);
    sample(1, -9000, -5000, 1000);
    sample(0, 50, -50, 10);
    repeat (30)
    begin
      ch = {$random(seed)} % 2;
      r = $random(seed) % 10001;
      c = $random(seed) % 5001;
      z = {$random(seed)} % 1001;
      sample(ch, r, c, z);
    end
    repeat (8)
    begin
      ceil = {$random(seed)} % 32'h4000 + 1;
      motorSpeedMax = {$random(seed)} % 32'h4000;
      analogSpeedLimit = {$random(seed)} % 32'h4000;
      digitalSpeedLimit = {$random(seed)} % 32'h4000;
      bus(1, ADDR_SPEED_CEIL, ceil);
      check(activeSpeedLimit, min4(ceil, motorSpeedMax, analogSpeedLimit,
                                   digitalSpeedLimit));
    end
    repeat (6)
    begin
      pinsIn = $random(seed);
      offIn = $random(seed);
      outIn = $random(seed);
      repeat (3) tick;
      for (int s = 0; s < 4; s++)
      begin
        displaySelect = s;
        tick;
        check(displayData, s == 0 ? pinsIn : s == 1 ? outIn :
                           s == 2 ? offIn : 0);
      end
      bus(0, ADDR_INPUT_PINS, 0);
      check(rd, pinsIn);
      bus(0, ADDR_OUTPUT_PINS, 0);
      check(rd, outIn);
      bus(0, ADDR_TORQUE_OFF, 0);
      check(rd, offIn);
    end
    stop_test;
  end
endmodule
